// File: src/smb_defs.svh
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH

// ************************************************
// bus address
// ************************************************
`define SMB_ADDR_HI     5'h0B
`define SMB_ADDR_RST    {`SMB_ADDR_HI, 2'h0}
`define SMB_SADDR_IDX   8'h4A
`define SMB_STRAP_WAIT  2'h2

// ************************************************
// framing
// ************************************************
`define SMB_BITS        4'h8
`define SMB_RX_FILL     8'hFF
`define SMB_IDX_PTR     2'h1
`define SMB_IDX_DATA    2'h2

// ************************************************
// timing
// ************************************************
`define SMB_CLK_NS      40
`define SMB_QTR_NS      160
`define SMB_QTR_CYC     ((`SMB_QTR_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_QTR_LOAD    3'(`SMB_QTR_CYC - 1)

`endif

// File: src/smb_pkg.sv
package smb_pkg;

   // ************************************************
   // device end
   // ************************************************
   typedef enum logic [5:0] {
      SMB_D_IDLE  = 6'h01,
      SMB_D_ADDR  = 6'h02,
      SMB_D_ACK   = 6'h04,
      SMB_D_WDATA = 6'h08,
      SMB_D_RDATA = 6'h10,
      SMB_D_RACK  = 6'h20
   } smb_dev_st_e;

   typedef struct packed {
      smb_dev_st_e state;
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_s3;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_s3;
      logic        stl_s1;
      logic        stl_s2;
      logic        sth_s1;
      logic        sth_s2;
      logic [1:0]  strap_cnt;
      logic        strap_done;
      logic [6:0]  addr;
      logic        rw;
      logic [3:0]  bitc;
      logic [7:0]  shreg;
      logic [1:0]  nbytes;
      logic [7:0]  ptr;
      logic        sda_oe;
      logic        wr_stb;
      logic [7:0]  wr_data;
      logic        rd_stb;
   } smb_dev_s;

   // ************************************************
   // master end
   // ************************************************
   typedef enum logic [3:0] {
      SMB_H_IDLE  = 4'h1,
      SMB_H_START = 4'h2,
      SMB_H_BIT   = 4'h4,
      SMB_H_STOP  = 4'h8
   } smb_host_st_e;

   typedef enum logic [1:0] {
      SMB_K_WR_PTR  = 2'h0,
      SMB_K_WR_DATA = 2'h1,
      SMB_K_RD      = 2'h2
   } smb_kind_e;

   typedef struct packed {
      smb_host_st_e state;
      logic         sda_s1;
      logic         sda_s2;
      logic [2:0]   qcnt;
      logic [1:0]   q;
      logic [3:0]   bitn;
      logic [1:0]   byte_idx;
      logic [1:0]   last_idx;
      smb_kind_e    kind;
      logic [6:0]   daddr;
      logic [7:0]   ptr;
      logic [7:0]   wdata;
      logic [7:0]   shreg;
      logic         ack;
      logic         scl_oe;
      logic         sda_oe;
      logic         done;
      logic         nack;
      logic [7:0]   rdata;
   } smb_host_s;

endpackage : smb_pkg

// File: src/smb_if.sv
`timescale 1ns/1ps
`default_nettype none

interface smb_if;
   // ************************************************
   // resolved wires, both pins open drain with pull-up
   // ************************************************
   logic scl;
   logic sda;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport dev (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe
   );

   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe
   );
endinterface : smb_if

`default_nettype wire

// File: src/smb_dev.sv
// How it works
// R1: address resets to fixed upper five plus straps
// R2: open straps give default address 0101100
// R3: address register write replaces upper five bits
// R4: answer only to the current address
// R5: master opens every transfer with START
// R6: shift in seven address bits, then direction
// R7: acknowledge match before ninth clock, else idle
// R8: direction zero writes, one reads
// R9: nine clocks per byte, ack last
// R10: data moves with clock low; rise-high is STOP
// R11: master ends a write with STOP
// R12: master ends a read with NACK, STOP
// R13: direction holds until a new START
// R14: writes carry one or two bytes, reads one
// R15: first written byte loads the pointer
// R16: second written byte goes to selected register
// R17: read returns selected register, pointer retained
// R18: unknown pointer needs pointer-only write first
// R19: data write always starts with the pointer
// R20: data line released unless acking or sending
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module smb_dev (
   // clock, reset, enable
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   // serial bus
   smb_if.dev              bus,
   // address straps
   input  wire logic       i_addr_strap_low,
   input  wire logic       i_addr_strap_high,
   // register file side
   output logic            o_wr_stb,
   output logic [7:0]      o_wr_data,
   output logic            o_rd_stb,
   output logic [7:0]      o_reg_addr,
   input  wire logic [7:0] i_rd_data,
   // status
   output logic [6:0]      o_dev_addr,
   output logic            o_busy
);

   // ************************************************
   // state
   // ************************************************
   smb_pkg::smb_dev_s r;
   smb_pkg::smb_dev_s n;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [7:0] rd_byte;

   // edge finders look at the second and third stages only
   assign scl_rise  = r.scl_s2 && !r.scl_s3;
   assign scl_fall  = !r.scl_s2 && r.scl_s3;
   assign start_det = r.scl_s2 && r.scl_s3 && !r.sda_s2 && r.sda_s3;      // see R5
   assign stop_det  = r.scl_s2 && r.scl_s3 && r.sda_s2 && !r.sda_s3;      // see R10

   // the address register lives here, everything else outside
   assign rd_byte = (r.ptr == `SMB_SADDR_IDX) ? {1'b0, r.addr} : i_rd_data;  // see R17

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      n        = r;
      n.wr_stb = 1'b0;
      n.rd_stb = 1'b0;

      n.scl_s1 = bus.scl;
      n.scl_s2 = r.scl_s1;
      n.scl_s3 = r.scl_s2;
      n.sda_s1 = bus.sda;
      n.sda_s2 = r.sda_s1;
      n.sda_s3 = r.sda_s2;
      n.stl_s1 = i_addr_strap_low;
      n.stl_s2 = r.stl_s1;
      n.sth_s1 = i_addr_strap_high;
      n.sth_s2 = r.sth_s1;

      // straps are caught once, after the synchronisers have filled
      if (!r.strap_done) begin
         n.strap_cnt = r.strap_cnt + 2'h1;
         if (r.strap_cnt == `SMB_STRAP_WAIT) begin
            n.addr[1:0]  = {r.sth_s2, r.stl_s2};                        // see R1, R2
            n.strap_done = 1'b1;
         end
      end

      if (!r.strap_done) begin
         n.state  = smb_pkg::SMB_D_IDLE;
         n.sda_oe = 1'b0;
      end else if (start_det) begin
         // a repeated start also lands here and drops any transfer
         n.state  = smb_pkg::SMB_D_ADDR;                                // see R13
         n.bitc   = 4'h0;
         n.nbytes = 2'h0;
         n.sda_oe = 1'b0;                                               // see R20
      end else if (stop_det) begin
         n.state  = smb_pkg::SMB_D_IDLE;                                // see R11, R12
         n.sda_oe = 1'b0;                                               // see R20
      end else begin
         case (r.state)
            smb_pkg::SMB_D_ADDR: begin
               if (scl_rise) begin
                  n.shreg = {r.shreg[6:0], r.sda_s2};                   // see R6
                  n.bitc  = r.bitc + 4'h1;
               end else if (scl_fall && r.bitc == `SMB_BITS) begin
                  // the fall after start itself has bitc zero and is skipped
                  if (r.shreg[7:1] == r.addr) begin                     // see R4
                     n.sda_oe = 1'b1;                                   // see R7
                     n.rw     = r.shreg[0];                             // see R8
                     n.state  = smb_pkg::SMB_D_ACK;
                  end else begin
                     n.state  = smb_pkg::SMB_D_IDLE;                    // see R7
                  end
               end
            end

            smb_pkg::SMB_D_ACK: begin
               if (scl_fall) begin
                  n.bitc = 4'h0;
                  if (r.rw) begin
                     n.shreg  = rd_byte;                                // see R17
                     n.sda_oe = !rd_byte[7];
                     n.rd_stb = 1'b1;
                     n.state  = smb_pkg::SMB_D_RDATA;
                  end else begin
                     n.sda_oe = 1'b0;                                   // see R20
                     n.state  = smb_pkg::SMB_D_WDATA;
                  end
               end
            end

            smb_pkg::SMB_D_WDATA: begin
               if (scl_rise) begin
                  n.shreg = {r.shreg[6:0], r.sda_s2};                   // see R10
                  n.bitc  = r.bitc + 4'h1;
               end else if (scl_fall && r.bitc == `SMB_BITS) begin      // see R9
                  n.nbytes = r.nbytes + 2'h1;
                  if (r.nbytes == 2'h0) begin
                     n.ptr = r.shreg;                                   // see R15, R19
                  end else if (r.ptr == `SMB_SADDR_IDX) begin
                     n.addr[6:2] = r.shreg[6:2];                        // see R3
                  end else begin
                     n.wr_stb  = 1'b1;                                  // see R16
                     n.wr_data = r.shreg;
                  end
                  if (r.nbytes == 2'h0) begin
                     n.sda_oe = 1'b1;
                     n.state  = smb_pkg::SMB_D_ACK;
                  end else begin
                     // a third byte would be one too many: ack this, then drop out
                     n.sda_oe = 1'b1;                                   // see R14
                     n.rw     = 1'b0;
                     n.state  = smb_pkg::SMB_D_RACK;
                  end
               end
            end

            smb_pkg::SMB_D_RDATA: begin
               if (scl_rise) begin
                  n.bitc = r.bitc + 4'h1;
               end else if (scl_fall) begin
                  if (r.bitc == `SMB_BITS) begin
                     n.sda_oe = 1'b0;                                   // see R20
                     n.state  = smb_pkg::SMB_D_RACK;
                  end else begin
                     n.shreg  = {r.shreg[6:0], 1'b0};
                     n.sda_oe = !r.shreg[6];                            // see R10
                  end
               end
            end

            smb_pkg::SMB_D_RACK: begin
               // one byte per read and two per write: the slot ends the transfer
               if (scl_fall) begin
                  n.sda_oe = 1'b0;                                      // see R14, R20
                  n.state  = smb_pkg::SMB_D_IDLE;
               end
            end

            default: begin
               n.sda_oe = 1'b0;                                         // see R20
               n.state  = smb_pkg::SMB_D_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r            <= '0;
         r.state      <= smb_pkg::SMB_D_IDLE;
         r.scl_s1     <= 1'b1;
         r.scl_s2     <= 1'b1;
         r.scl_s3     <= 1'b1;
         r.sda_s1     <= 1'b1;
         r.sda_s2     <= 1'b1;
         r.sda_s3     <= 1'b1;
         r.addr       <= `SMB_ADDR_RST;                                 // see R1
      end else if (i_ce) begin
         r <= n;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = r.sda_oe;
   assign o_wr_stb       = r.wr_stb;
   assign o_wr_data      = r.wr_data;
   assign o_rd_stb       = r.rd_stb;
   assign o_reg_addr     = r.ptr;
   assign o_dev_addr     = r.addr;
   assign o_busy         = (r.state != smb_pkg::SMB_D_IDLE);

endmodule : smb_dev

`default_nettype wire

// File: src/smb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module smb_host (
   // clock, reset, enable
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   // serial bus
   smb_if.host             bus,
   // command
   input  wire logic       i_cmd_valid,
   output logic            o_cmd_ready,
   input  wire logic [1:0] i_cmd_kind,
   input  wire logic [6:0] i_dev_addr,
   input  wire logic [7:0] i_ptr,
   input  wire logic [7:0] i_wdata,
   // answer
   output logic            o_done,
   output logic            o_nack,
   output logic [7:0]      o_rdata
);

   // ************************************************
   // state
   // ************************************************
   smb_pkg::smb_host_s r;
   smb_pkg::smb_host_s n;
   logic               rx_byte;

   assign rx_byte = (r.kind == smb_pkg::SMB_K_RD) && (r.byte_idx == `SMB_IDX_PTR);

   // ************************************************
   // next state; each quarter of the clock period ends in one action
   // ************************************************
   always_comb begin
      n        = r;
      n.done   = 1'b0;
      n.sda_s1 = bus.sda;
      n.sda_s2 = r.sda_s1;

      if (r.state == smb_pkg::SMB_H_IDLE) begin
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
         if (i_cmd_valid) begin
            n.kind     = smb_pkg::smb_kind_e'(i_cmd_kind);
            n.daddr    = i_dev_addr;                                    // see R4
            n.ptr      = i_ptr;
            n.wdata    = i_wdata;
            n.nack     = 1'b0;
            n.q        = 2'h0;
            n.qcnt     = `SMB_QTR_LOAD;
            n.last_idx = (smb_pkg::smb_kind_e'(i_cmd_kind) == smb_pkg::SMB_K_WR_DATA) ?
                         `SMB_IDX_DATA : `SMB_IDX_PTR;                  // see R14, R18
            n.state    = smb_pkg::SMB_H_START;
         end
      end else if (r.qcnt != 3'h0) begin
         n.qcnt = r.qcnt - 3'h1;
      end else begin
         n.qcnt = `SMB_QTR_LOAD;
         n.q    = r.q + 2'h1;
         case (r.state)
            smb_pkg::SMB_H_START: begin
               if (r.q == 2'h0) begin
                  n.sda_oe = 1'b1;                                      // see R5
               end else begin
                  n.scl_oe   = 1'b1;
                  n.q        = 2'h0;
                  n.bitn     = 4'h0;
                  n.byte_idx = 2'h0;
                  n.shreg    = {r.daddr, r.kind == smb_pkg::SMB_K_RD};  // see R8, R13
                  n.state    = smb_pkg::SMB_H_BIT;
               end
            end

            smb_pkg::SMB_H_BIT: begin
               case (r.q)
                  2'h0: n.sda_oe = (r.bitn != `SMB_BITS) && !r.shreg[7];  // see R10, R12
                  2'h1: n.scl_oe = 1'b0;
                  2'h2: begin
                     if (r.bitn == `SMB_BITS) begin
                        n.ack = r.sda_s2;
                     end else begin
                        n.shreg = {r.shreg[6:0], r.sda_s2};
                     end
                  end
                  default: begin
                     n.scl_oe = 1'b1;
                     n.bitn   = r.bitn + 4'h1;
                     if (r.bitn == `SMB_BITS) begin                     // see R9
                        n.bitn = 4'h0;
                        if (rx_byte) begin
                           n.rdata = r.shreg;
                        end
                        if (r.ack && !rx_byte) begin
                           n.nack  = 1'b1;
                           n.state = smb_pkg::SMB_H_STOP;
                        end else if (r.byte_idx == r.last_idx) begin
                           n.state = smb_pkg::SMB_H_STOP;               // see R11, R12
                        end else begin
                           n.byte_idx = r.byte_idx + 2'h1;
                           if (r.byte_idx == 2'h0) begin
                              n.shreg = (r.kind == smb_pkg::SMB_K_RD) ?
                                        `SMB_RX_FILL : r.ptr;           // see R19
                           end else begin
                              n.shreg = r.wdata;
                           end
                        end
                     end
                  end
               endcase
            end

            smb_pkg::SMB_H_STOP: begin
               case (r.q)
                  2'h0: n.sda_oe = 1'b1;
                  2'h1: n.scl_oe = 1'b0;
                  2'h2: n.sda_oe = 1'b0;                                // see R10, R11
                  default: begin
                     n.done  = 1'b1;
                     n.state = smb_pkg::SMB_H_IDLE;
                  end
               endcase
            end

            default: n.state = smb_pkg::SMB_H_IDLE;
         endcase
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r        <= '0;
         r.state  <= smb_pkg::SMB_H_IDLE;
         r.sda_s1 <= 1'b1;
         r.sda_s2 <= 1'b1;
      end else if (i_ce) begin
         r <= n;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign bus.host_scl_o  = 1'b0;
   assign bus.host_scl_oe = r.scl_oe;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = r.sda_oe;
   assign o_cmd_ready     = (r.state == smb_pkg::SMB_H_IDLE);
   assign o_done          = r.done;
   assign o_nack          = r.nack;
   assign o_rdata         = r.rdata;

endmodule : smb_host

`default_nettype wire

// File: verif/smb_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module smb_chk (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // bus wires
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   // ************************************************
   // frame tracking
   // ************************************************
   logic       scl_q;
   logic       sda_q;
   logic       rw_q;
   logic [4:0] cnt_q;
   wire        rise  = scl && !scl_q;
   wire        start = scl && scl_q && sda_q && !sda;
   wire        stop  = scl && scl_q && !sda_q && sda;

   // cnt_q counts clock rises since start; the stop clock counts as well
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rw_q  <= 1'b0;
         cnt_q <= 5'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start) begin
            cnt_q <= 5'h00;
         end else if (rise) begin
            cnt_q <= cnt_q + 5'h01;
         end
         if (rise && cnt_q == 5'h07) begin
            rw_q <= sda;
         end
      end
   end

   // ************************************************
   // properties
   // ************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   chk_addr_listen: assert property (rise && cnt_q < 5'h08 |-> !dev_sda_oe)
      else $error("device drove during the address byte");
   chk_ack_slot: assert property (rise && cnt_q == 5'h08 |-> !host_sda_oe)
      else $error("master held data in the address ack slot");
   chk_write_quiet: assert property (rise && !rw_q && cnt_q > 5'h08 && cnt_q != 5'h11 && cnt_q != 5'h1A
      |-> !dev_sda_oe)
      else $error("device drove data bits of a write");
   chk_read_nack: assert property (rise && rw_q && cnt_q == 5'h11 |-> !dev_sda_oe && sda)
      else $error("read byte not ended by a released nack slot");
   chk_byte_limit: assert property (rise |-> cnt_q < (rw_q ? 5'h13 : 5'h1C))
      else $error("too many clocks in one operation");
   chk_high_share: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
      else $error("both ends drive data while clock is high");
   chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device changed data while clock is high");
   chk_drive_hold: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*3])
      else $error("device drive did not stand");
   chk_frame_free: assert property (start || stop |-> !dev_sda_oe)
      else $error("device driving at a start or stop");
endmodule : smb_chk

`default_nettype wire

// File: verif/smbus_slave_register_port_test.sv
`timescale 1ns/1ps
`default_nettype none

module smbus_slave_register_port_test;
   // ************************************************
   // stimulus and observed signals
   // ************************************************
   logic       i_mclk    = 1'b0;
   logic       i_rst_n   = 1'b0;
   logic [1:0] strap     = 2'h0;
   logic       cmd_valid = 1'b0;
   logic [1:0] cmd_kind  = 2'h0;
   logic [6:0] cmd_addr  = 7'h00;
   logic [7:0] cmd_ptr   = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic       wr_stb, rd_stb, busy, cmd_ready, done, nack;
   logic [7:0] wr_data, reg_addr, rd_data, rdata;
   logic [6:0] dev_addr;
   logic [7:0] regs [256];
   int         miscompares = 0;
   int         compares    = 0;
   int         cycles      = 0;
   int         wr_seen     = 0;
   int         rd_seen     = 0;

   always #20 i_mclk = ~i_mclk;
   assign rd_data = regs[reg_addr];

   smb_if u_smb_if ();
   smb_dev u_smb_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .bus(u_smb_if),
      .i_addr_strap_low(strap[0]), .i_addr_strap_high(strap[1]), .o_wr_stb(wr_stb),
      .o_wr_data(wr_data), .o_rd_stb(rd_stb), .o_reg_addr(reg_addr), .i_rd_data(rd_data),
      .o_dev_addr(dev_addr), .o_busy(busy));
   smb_host u_smb_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .bus(u_smb_if),
      .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_kind(cmd_kind),
      .i_dev_addr(cmd_addr), .i_ptr(cmd_ptr), .i_wdata(cmd_wdata), .o_done(done),
      .o_nack(nack), .o_rdata(rdata));
   smb_chk u_smb_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .scl(u_smb_if.scl), .sda(u_smb_if.sda),
      .host_sda_oe(u_smb_if.host_sda_oe), .dev_sda_oe(u_smb_if.dev_sda_oe));

   // register file behind the device; ceiling is about six times the planned run
   always @(posedge i_mclk) begin
      cycles++;
      // one known register, loaded while reset stands so it has a single writer
      if (i_rst_n === 1'b0) begin
         regs[8'h07] <= 8'h3C;
      end
      if (wr_stb === 1'b1) begin
         wr_seen++;
         regs[reg_addr] <= wr_data;
      end
      if (rd_stb === 1'b1) begin
         rd_seen++;
      end
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic do_reset(input logic [1:0] s);
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      strap   <= s;
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (8) @(posedge i_mclk);
   endtask : do_reset

   task automatic run_cmd(input logic [1:0] k, input logic [6:0] a, input logic [7:0] p,
                          input logic [7:0] d);
      int   n;
      logic seen_busy;
      @(posedge i_mclk);
      cmd_kind  <= k;
      cmd_addr  <= a;
      cmd_ptr   <= p;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      do @(negedge i_mclk); while (cmd_ready !== 1'b1);
      @(posedge i_mclk);
      cmd_valid <= 1'b0;
      n         = 0;
      seen_busy = 1'b0;
      do begin
         @(negedge i_mclk);
         n++;
         if (busy === 1'b1) begin
            seen_busy = 1'b1;
         end
      end while (done !== 1'b1 && n < 2000);
      check("command done", 8'h01, {7'h00, done});
      check("device busy seen", 8'h01, {7'h00, seen_busy});
      check("device idle", 8'h00, {7'h00, busy});
   endtask : run_cmd

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_default_addr();
      do_reset(2'h0);
      check("bus address", 8'h2C, {1'b0, dev_addr});
      run_cmd(2'h0, 7'h2C, 8'h01, 8'h00);
      check("nack", 8'h00, {7'h00, nack});
   endtask : t_default_addr

   task automatic t_ptr_read();
      int w;
      int r;
      w = wr_seen;
      run_cmd(2'h0, 7'h2C, 8'h07, 8'h00);
      check("pointer", 8'h07, reg_addr);
      check("write strobes", 8'(w), 8'(wr_seen));
      r = rd_seen;
      for (int i = 0; i < 2; i++) begin
         run_cmd(2'h2, 7'h2C, 8'h00, 8'h00);
         check("read data", 8'h3C, rdata);
      end
      check("read strobes", 8'(r + 2), 8'(rd_seen));
   endtask : t_ptr_read

   task automatic t_write_read();
      int w;
      w = wr_seen;
      run_cmd(2'h1, 7'h2C, 8'h13, 8'hA5);
      check("write strobes", 8'(w + 1), 8'(wr_seen));
      check("pointer", 8'h13, reg_addr);
      check("write data", 8'hA5, wr_data);
      run_cmd(2'h2, 7'h2C, 8'h00, 8'h00);
      check("read data", 8'hA5, rdata);
      check("nack", 8'h00, {7'h00, nack});
   endtask : t_write_read

   task automatic t_wrong_addr();
      int w;
      w = wr_seen;
      run_cmd(2'h1, 7'h2D, 8'h20, 8'h99);
      check("nack", 8'h01, {7'h00, nack});
      check("pointer", 8'h13, reg_addr);
      check("write strobes", 8'(w), 8'(wr_seen));
   endtask : t_wrong_addr

   task automatic t_reprogram();
      do_reset(2'h3);
      check("bus address", 8'h2F, {1'b0, dev_addr});
      run_cmd(2'h1, 7'h2F, 8'h4A, 8'h54);
      check("bus address", 8'h57, {1'b0, dev_addr});
      run_cmd(2'h2, 7'h57, 8'h00, 8'h00);
      check("address readback", 8'h57, rdata);
      run_cmd(2'h0, 7'h2F, 8'h01, 8'h00);
      check("old address nack", 8'h01, {7'h00, nack});
      run_cmd(2'h0, 7'h57, 8'h01, 8'h00);
      check("new address nack", 8'h00, {7'h00, nack});
   endtask : t_reprogram

   initial begin
      t_default_addr();
      t_ptr_read();
      t_write_read();
      t_wrong_addr();
      t_reprogram();
      finish_test();
   end
endmodule : smbus_slave_register_port_test

`default_nettype wire
